// file: verilog/gsp_cfg.svh
`ifndef GSP_CFG_SVH
`define GSP_CFG_SVH

// frame geometry, counted in falling serial clock edges
`define GSP_FRAME_BITS  5'h10
`define GSP_CTRL_BITS   5'h0c
`define GSP_ADDR_EDGE   5'h01
`define GSP_MUX_EDGE    5'h0d
`define GSP_LAST_EDGE   5'h0f

// control word fields
`define GSP_WR_BIT      11
`define GSP_CH_HI       7
`define GSP_CH_LO       6
`define GSP_CODE_BIT    0

// reset values
`define GSP_CTRL_RST    12'h030
`define GSP_MUX_RST     2'h0
`define GSP_WORD_RST    14'h0000

// straight binary to two's complement flips the top bit
`define GSP_TC_FLIP     12'h800

`endif

// file: verilog/gsp_pkg.sv
package gsp_pkg;

    typedef enum logic [2:0] {
        GSP_IDLE = 3'h1,
        GSP_BUSY = 3'h2,
        GSP_PEND = 3'h4
    } gsp_conv_e;

    typedef logic [13:0] gsp_word_t;

endpackage : gsp_pkg

// file: verilog/gsp_evt_if.sv
`timescale 1ns/1ps
// one toggle per event, crossing from the link clock to CLK
interface gsp_evt_if;
    logic tog;
    modport src (output tog);
    modport dst (input tog);
endinterface : gsp_evt_if

// file: verilog/gsp_sync2.sv
`timescale 1ns/1ps
module gsp_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] q_next;

    // first stage feeds only the second; resets to idle high
    always_comb begin
        meta_next = reset ? {WIDTH{1'b1}} : d;
        q_next    = reset ? {WIDTH{1'b1}} : meta_reg;
    end

    always_ff @(posedge clk) begin
        meta_reg <= meta_next;
        q        <= q_next;
    end
endmodule : gsp_sync2

// file: verilog/gsp_evt_rx.sv
`timescale 1ns/1ps
module gsp_evt_rx (
    input  wire logic  clk,
    input  wire logic  reset,
    gsp_evt_if.dst     evt,
    output logic       pulse
);
    logic [2:0] sh_reg;
    logic [2:0] sh_next;

    // two stages to settle, third only for the edge compare
    always_comb begin
        sh_next = reset ? 3'h0 : {sh_reg[1:0], evt.tog};
    end

    always_ff @(posedge clk) begin
        sh_reg <= sh_next;
    end

    assign pulse = sh_reg[1] ^ sh_reg[2];

    // one pulse per toggle, never a held level
    evt_single_a:
    assert property (@(posedge clk) disable iff (reset)
        pulse |=> !pulse || (sh_reg[1] != $past(sh_reg[1])))
        else $error("event pulse held longer than one cycle");
endmodule : gsp_evt_rx

// file: verilog/gsp_top.sv
`timescale 1ns/1ps
`include "gsp_cfg.svh"
module gsp_top (
    input  wire logic        CLK,
    input  wire logic        RESET,
    input  wire logic        SCLK,
    input  wire logic        CS_N,
    input  wire logic        DIN,
    output logic             DOUT_O,
    output logic             DOUT_OE,
    input  wire logic [11:0] ADC_DATA,
    input  wire logic        ADC_DONE,
    output logic             CONV_START,
    output logic [1:0]       CONV_CHANNEL,
    output logic [1:0]       MUX_CHANNEL,
    output logic [11:0]      CTRL_WORD,
    output logic             CODING_STRAIGHT,
    output logic             FRAME_ACTIVE,
    output logic             FRAME_DONE,
    output logic             FRAME_ABORT
);
    // ---- link side, clocked on falling serial clock edges
    logic                link_clr;
    logic [4:0]          cnt_reg;
    logic [4:0]          cnt_next;
    logic [11:0]         rx_reg;
    logic [11:0]         rx_next;
    gsp_pkg::gsp_word_t  tx_reg;
    gsp_pkg::gsp_word_t  tx_next;
    logic                done_tog_reg;
    logic                done_tog_next;
    logic                mux_tog_reg;
    logic                mux_tog_next;

    // ---- system side
    gsp_pkg::gsp_word_t  word_hold_reg;
    gsp_pkg::gsp_word_t  word_hold_next;
    gsp_pkg::gsp_word_t  pend_reg;
    gsp_pkg::gsp_word_t  pend_next;
    gsp_pkg::gsp_conv_e  state_reg;
    gsp_pkg::gsp_conv_e  state_next;
    logic [11:0]         ctrl_reg;
    logic [11:0]         ctrl_next;
    logic [1:0]          mux_reg;
    logic [1:0]          mux_next;
    logic                code_reg;
    logic                code_next;
    logic [1:0]          chan_reg;
    logic [1:0]          chan_next;
    logic                start_reg;
    logic                start_next;
    logic                cs_prev_reg;
    logic                cs_prev_next;
    logic                seen_reg;
    logic                seen_next;
    logic                fdone_reg;
    logic                fdone_next;
    logic                abort_reg;
    logic                abort_next;
    logic                cs_n_s;
    logic                done_p;
    logic                mux_p;
    logic                cs_rise;
    logic                cs_fall;

    gsp_evt_if done_if ();
    gsp_evt_if mux_if ();

    // select high holds the bit counter and output shift idle; no edge is counted on
    assign link_clr = CS_N | RESET;

    // bit position, input shift and output shift for one frame
    always_comb begin
        cnt_next = cnt_reg;
        rx_next  = rx_reg;
        tx_next  = tx_reg;
        if (cnt_reg != `GSP_FRAME_BITS) begin
            cnt_next = cnt_reg + 5'h01;
        end
        if (cnt_reg < `GSP_CTRL_BITS) begin
            rx_next = {rx_reg[10:0], DIN};
        end
        if (cnt_reg == `GSP_ADDR_EDGE) begin
            tx_next = word_hold_reg;
        end else if (cnt_reg > `GSP_ADDR_EDGE) begin
            tx_next = {tx_reg[12:0], 1'b0};
        end
    end

    // cleared while idle, so the first two periods drive low
    always_ff @(negedge SCLK or posedge link_clr) begin
        if (link_clr) begin
            cnt_reg <= 5'h00;
            tx_reg  <= `GSP_WORD_RST;
        end else begin
            cnt_reg <= cnt_next;
            tx_reg  <= tx_next;
        end
    end

    // received bits must survive the select rise for the crossing
    always_ff @(negedge SCLK or posedge RESET) begin
        if (RESET) begin
            rx_reg <= 12'h000;
        end else begin
            rx_reg <= rx_next;
        end
    end

    // toggles mark the fourteenth and sixteenth falling edges
    always_comb begin
        done_tog_next = done_tog_reg ^ (cnt_reg == `GSP_LAST_EDGE);
        mux_tog_next  = mux_tog_reg ^ (cnt_reg == `GSP_MUX_EDGE);
    end

    always_ff @(negedge SCLK or posedge RESET) begin
        if (RESET) begin
            done_tog_reg <= 1'b0;
            mux_tog_reg  <= 1'b0;
        end else begin
            done_tog_reg <= done_tog_next;
            mux_tog_reg  <= mux_tog_next;
        end
    end

    assign done_if.tog = done_tog_reg;
    assign mux_if.tog  = mux_tog_reg;

    // pin drive: released on select high or after the last edge
    assign DOUT_O  = tx_reg[13];
    assign DOUT_OE = ~link_clr & (cnt_reg != `GSP_FRAME_BITS);

    // ---- crossings into the system clock
    gsp_sync2 #(
        .WIDTH (1)
    ) u_cs_sync (
        .clk   (CLK),
        .reset (RESET),
        .d     (CS_N),
        .q     (cs_n_s)
    );

    gsp_evt_rx u_done_rx (
        .clk   (CLK),
        .reset (RESET),
        .evt   (done_if),
        .pulse (done_p)
    );

    gsp_evt_rx u_mux_rx (
        .clk   (CLK),
        .reset (RESET),
        .evt   (mux_if),
        .pulse (mux_p)
    );

    assign cs_rise = cs_n_s & ~cs_prev_reg;
    assign cs_fall = ~cs_n_s & cs_prev_reg;

    // frame bookkeeping; a completed frame wins over the select rise
    always_comb begin
        cs_prev_next = cs_n_s;
        seen_next    = seen_reg;
        if (cs_fall) begin
            seen_next = 1'b0;
        end
        if (done_p) begin
            seen_next = 1'b1;
        end
        fdone_next = done_p;
        abort_next = cs_rise & ~seen_reg & ~done_p;
        if (RESET) begin
            cs_prev_next = 1'b1;
            seen_next    = 1'b0;
            fdone_next   = 1'b0;
            abort_next   = 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        cs_prev_reg <= cs_prev_next;
        seen_reg    <= seen_next;
        fdone_reg   <= fdone_next;
        abort_reg   <= abort_next;
    end

    // control word and mux select follow the write bit
    always_comb begin
        ctrl_next = ctrl_reg;
        mux_next  = mux_reg;
        if (done_p && rx_reg[`GSP_WR_BIT]) begin
            ctrl_next = rx_reg;
        end
        if (mux_p && rx_reg[`GSP_WR_BIT]) begin
            mux_next = {rx_reg[`GSP_CH_HI], rx_reg[`GSP_CH_LO]};
        end
        if (RESET) begin
            ctrl_next = `GSP_CTRL_RST;
            mux_next  = `GSP_MUX_RST;
        end
    end

    // an aborted frame never raises done_p, so ctrl_reg is not loaded; mux_reg still loads once mux_p fires on the 14th edge
    always_ff @(posedge CLK) begin
        ctrl_reg <= ctrl_next;
        mux_reg  <= mux_next;
    end

    // conversion: started by a complete frame arriving in GSP_IDLE, then published
    always_comb begin
        state_next     = state_reg;
        start_next     = 1'b0;
        chan_next      = chan_reg;
        code_next      = code_reg;
        pend_next      = pend_reg;
        word_hold_next = word_hold_reg;
        case (state_reg)
            gsp_pkg::GSP_IDLE: begin
                if (done_p) begin
                    start_next = 1'b1;
                    chan_next  = mux_reg;
                    code_next  = ctrl_next[`GSP_CODE_BIT];
                    state_next = gsp_pkg::GSP_BUSY;
                end
            end
            gsp_pkg::GSP_BUSY: begin
                if (ADC_DONE) begin
                    pend_next = {chan_reg, code_reg ? ADC_DATA
                                 : (ADC_DATA ^ `GSP_TC_FLIP)};
                    state_next = gsp_pkg::GSP_PEND;
                end
            end
            gsp_pkg::GSP_PEND: begin
                // only swap the word while no frame can be reading it
                if (cs_n_s && cs_prev_reg) begin
                    word_hold_next = pend_reg;
                    state_next     = gsp_pkg::GSP_IDLE;
                end
            end
            default: begin
                state_next = gsp_pkg::GSP_IDLE;
            end
        endcase
        if (RESET) begin
            state_next     = gsp_pkg::GSP_IDLE;
            start_next     = 1'b0;
            chan_next      = 2'h0;
            code_next      = 1'b0;
            pend_next      = `GSP_WORD_RST;
            word_hold_next = `GSP_WORD_RST;
        end
    end

    always_ff @(posedge CLK) begin
        state_reg     <= state_next;
        start_reg     <= start_next;
        chan_reg      <= chan_next;
        code_reg      <= code_next;
        pend_reg      <= pend_next;
        word_hold_reg <= word_hold_next;
    end

    assign CONV_START      = start_reg;
    assign CONV_CHANNEL    = chan_reg;
    assign MUX_CHANNEL     = mux_reg;
    assign CTRL_WORD       = ctrl_reg;
    assign CODING_STRAIGHT = ctrl_reg[`GSP_CODE_BIT];
    assign FRAME_ACTIVE    = ~cs_n_s;
    assign FRAME_DONE      = fdone_reg;
    assign FRAME_ABORT     = abort_reg;

    // ---- checks on the link side
    sequence s_lead;
        cnt_reg < 5'h02;
    endsequence

    sequence s_addr_load;
        cnt_reg == `GSP_ADDR_EDGE;
    endsequence

    sequence s_data_shift;
        (cnt_reg > `GSP_ADDR_EDGE) && (cnt_reg < `GSP_LAST_EDGE);
    endsequence

    sequence s_last_edge;
        cnt_reg == `GSP_LAST_EDGE;
    endsequence

    lead_low_a:
    assert property (@(negedge SCLK) disable iff (RESET || CS_N)
        s_lead |-> (DOUT_O == 1'b0))
        else $error("output not low in leading periods");

    addr_out_a:
    assert property (@(negedge SCLK) disable iff (RESET || CS_N)
        s_addr_load |=> (DOUT_O == $past(word_hold_reg[13])))
        else $error("channel address high bit not driven");

    data_shift_a:
    assert property (@(negedge SCLK) disable iff (RESET || CS_N)
        s_data_shift |=> (DOUT_O == $past(tx_reg[12])))
        else $error("result bit out of order");

    tail_ignore_a:
    assert property (@(negedge SCLK) disable iff (RESET || CS_N)
        (cnt_reg >= `GSP_CTRL_BITS) |=> $stable(rx_reg))
        else $error("input sampled after twelfth edge");

    // rising edge after the last fall comes while select is still low
    last_release_a:
    assert property (@(posedge SCLK) disable iff (RESET || CS_N)
        s_last_edge |=> !DOUT_OE)
        else $error("output still driven after sixteenth edge");

    // ---- checks on the system side
    cs_release_a:
    assert property (@(posedge CLK) disable iff (RESET)
        CS_N |-> !DOUT_OE)
        else $error("output driven while select high");

    ctrl_load_a:
    assert property (@(posedge CLK) disable iff (RESET)
        (done_p && rx_reg[`GSP_WR_BIT]) |=>
            (CTRL_WORD == $past(rx_reg)) && FRAME_DONE)
        else $error("control word not loaded");

    ctrl_keep_a:
    assert property (@(posedge CLK) disable iff (RESET)
        (done_p && !rx_reg[`GSP_WR_BIT]) |=> $stable(CTRL_WORD))
        else $error("control word changed without write bit");

    abort_keep_a:
    assert property (@(posedge CLK) disable iff (RESET)
        FRAME_ABORT |-> $stable(CTRL_WORD) && !FRAME_DONE)
        else $error("aborted frame changed control word");

    mux_switch_a:
    assert property (@(posedge CLK) disable iff (RESET)
        (mux_p && rx_reg[`GSP_WR_BIT]) |=>
            (MUX_CHANNEL == $past(rx_reg[`GSP_CH_HI:`GSP_CH_LO])))
        else $error("mux not switched to new channel");

    coding_a:
    assert property (@(posedge CLK) disable iff (RESET)
        (state_reg == gsp_pkg::GSP_BUSY && ADC_DONE) |=>
            pend_reg[11:0] == ($past(ADC_DATA)
                ^ ($past(code_reg) ? 12'h000 : `GSP_TC_FLIP)))
        else $error("result coding wrong");

    conv_start_a:
    assert property (@(posedge CLK) disable iff (RESET)
        (state_reg == gsp_pkg::GSP_IDLE && done_p) |=>
            CONV_START ##1 !CONV_START)
        else $error("conversion not started by frame");
endmodule : gsp_top

// file: test/gsp_host.sv
`timescale 1ns/1ps
// serial master: link clock idles high and stands still between frames
module gsp_host (
    output logic sclk,
    output logic cs_n,
    output logic din,
    input  wire logic dout_o,
    input  wire logic dout_oe
);
    wire dout_line = dout_oe ? dout_o : 1'bz;

    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din  = 1'b0;
    end

    // one frame of edges falling edges, 80 ns period; early stop aborts
    task automatic frame(input logic [11:0] ctrl, input int edges,
                         output logic [15:0] rx, output logic oe_bad);
        rx     = '0;
        oe_bad = 1'b0;
        cs_n   = 1'b0;
        din    = ctrl[11];
        #20;
        if (dout_oe !== 1'b1) oe_bad = 1'b1;
        rx[15] = dout_line;
        #20;
        for (int k = 1; k <= edges; k++) begin
            sclk = 1'b0;
            #40;
            sclk = 1'b1;
            if (k < 16) rx[15-k] = dout_line;
            if (k == 16 && dout_oe !== 1'b0) oe_bad = 1'b1;
            // tail bits toggle so an unignored input would show
            din = (k < 12) ? ctrl[11-k] : ~din;
            #40;
        end
        cs_n = 1'b1;
        #1;
        if (dout_oe !== 1'b0) oe_bad = 1'b1;
        din = ~din; // released line does not keep its last value
    endtask : frame
endmodule : gsp_host

// file: test/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic        CLK, RESET, ADC_DONE, conv_d;
    logic [11:0] ADC_DATA;
    logic        SCLK, CS_N, DIN, DOUT_O, DOUT_OE;
    logic        CONV_START, CODING_STRAIGHT;
    logic        FRAME_ACTIVE, FRAME_DONE, FRAME_ABORT;
    logic [1:0]  CONV_CHANNEL, MUX_CHANNEL;
    logic [11:0] CTRL_WORD, ctrl;
    logic [15:0] rx, exp;
    logic        bad;
    int          miscompares, check_count;
    logic [11:0] adc_val [4] = '{12'h123, 12'h456, 12'h789, 12'hfed};

    gsp_host host (
        .sclk    (SCLK),
        .cs_n    (CS_N),
        .din     (DIN),
        .dout_o  (DOUT_O),
        .dout_oe (DOUT_OE)
    );

    gsp_top dut (
        .CLK             (CLK),
        .RESET           (RESET),
        .SCLK            (SCLK),
        .CS_N            (CS_N),
        .DIN             (DIN),
        .DOUT_O          (DOUT_O),
        .DOUT_OE         (DOUT_OE),
        .ADC_DATA        (ADC_DATA),
        .ADC_DONE        (ADC_DONE),
        .CONV_START      (CONV_START),
        .CONV_CHANNEL    (CONV_CHANNEL),
        .MUX_CHANNEL     (MUX_CHANNEL),
        .CTRL_WORD       (CTRL_WORD),
        .CODING_STRAIGHT (CODING_STRAIGHT),
        .FRAME_ACTIVE    (FRAME_ACTIVE),
        .FRAME_DONE      (FRAME_DONE),
        .FRAME_ABORT     (FRAME_ABORT)
    );

    initial begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end

    // converter stand-in: answers two cycles after each start
    always @(posedge CLK) begin
        conv_d   <= CONV_START;
        ADC_DONE <= conv_d;
        if (CONV_START === 1'b1) ADC_DATA <= adc_val[CONV_CHANNEL];
    end

    task automatic check(input string what, input logic [15:0] e, g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask : check

    task automatic tally_and_finish();
        if (miscompares == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : tally_and_finish

    // bounded wait for a one-cycle pulse, sampled away from the edge
    task automatic wait_for(ref logic sig, input string what);
        int n;
        for (n = 0; n < 20 && sig !== 1'b1; n++) @(negedge CLK);
        check(what, 16'h1, {15'h0, sig});
    endtask : wait_for

    // full frame ends: conversion starts on the new channel
    task automatic frame_end(input logic [1:0] ch);
        wait_for(FRAME_DONE, "frame_done");
        check("conv_start", 16'h1, {15'h0, CONV_START});
        check("conv_channel", {14'h0, ch}, {14'h0, CONV_CHANNEL});
        repeat (12) @(negedge CLK);
    endtask : frame_end

    initial begin
        RESET = 1'b1;
        ADC_DONE = 1'b0;
        ADC_DATA = 12'h000;
        conv_d = 1'b0;
        miscompares = 0;
        check_count = 0;
        repeat (5) @(posedge CLK);
        RESET <= 1'b0;
        repeat (4) @(negedge CLK);
        check("ctrl_rst", 16'h030, {4'h0, CTRL_WORD});
        check("mux_rst", 16'h0, {14'h0, MUX_CHANNEL});
        check("oe_rst", 16'h0, {15'h0, DOUT_OE});
        check("active_rst", 16'h0, {15'h0, FRAME_ACTIVE});
        exp = 16'h0000;
        // every channel code, coding alternating
        for (int i = 0; i < 4; i++) begin
            ctrl = {4'h8, 2'(i), 5'h18, 1'(i)};
            host.frame(ctrl, 16, rx, bad);
            check("dout", exp, rx);
            check("oe_bad", 16'h0, {15'h0, bad});
            frame_end(2'(i));
            check("ctrl", {5'h0, ctrl[10:0]}, {5'h0, CTRL_WORD[10:0]});
            check("mux", {14'h0, 2'(i)}, {14'h0, MUX_CHANNEL});
            check("coding", {15'h0, ctrl[0]}, {15'h0, CODING_STRAIGHT});
            exp = {2'b00, 2'(i), adc_val[i] ^ (i[0] ? 12'h000 : 12'h800)};
        end
        // write flag low: control register and mux stay put
        host.frame(12'h0b0, 16, rx, bad);
        check("dout_nw", exp, rx);
        frame_end(2'b11);
        check("ctrl_nw", {5'h0, ctrl[10:0]}, {5'h0, CTRL_WORD[10:0]});
        check("mux_nw", 16'h3, {14'h0, MUX_CHANNEL});
        // abort after fourteen edges: mux moved, control discarded
        host.frame(12'h8b0, 14, rx, bad);
        check("dout_ab", {2'b00, exp[15:2]}, {2'b00, rx[15:2]});
        check("oe_ab", 16'h0, {15'h0, bad});
        wait_for(FRAME_ABORT, "frame_abort");
        check("ctrl_ab", {5'h0, ctrl[10:0]}, {5'h0, CTRL_WORD[10:0]});
        check("mux_ab", 16'h2, {14'h0, MUX_CHANNEL});
        tally_and_finish();
    end

    // whole run is under twenty microseconds
    initial begin
        #200000;
        miscompares++;
        tally_and_finish();
    end
endmodule : testbench
